//--- core/rxeq_regs.v
// Function
// - Sign bit and offset field form a two's complement shift, -8 to +7
// - Threshold code sets DAC limit, 40mV steps
// - Offset field shifts full adaptive result
// - Offset applied only in full adaptive modes
// - Long channel value drives connector receiver 2
// - Long channel value drives connector receiver 1
// - Adaptation off: connector fields set receivers
// - Override low: connector fields show straps
// - Override high: written connector values apply
// - Fast short channel uses connector field 2
// - Fast short channel uses connector field 1
// - Host field 2, straps when override low
// - Override high: written host values apply
// - Host field 1 follows same behaviour
// - Mode code zero fast, others full
// - Enable bit switches adaptation on/off
// - Override bit chooses straps or registers
// - Channel flag reports long/short in fast mode, zero otherwise
`timescale 1ns/100ps
`include "rxeq_map.vh"

module rxeq_regs #(
  parameter [6:0] I2C_ADDR = 7'h2C
) (
  input  wire       i_clk,                     // 20 MHz device clock
  input  wire       i_rst_b,                   // Async reset, low active
  input  wire       i_scl,                     // Serial clock pin
  input  wire       i_sda,                     // Serial data pin level
  output wire       o_sda_out,                 // Serial data drive level
  output wire       o_sda_oe,                  // Serial data drive enable
  input  wire [1:0] i_connector_eq_straps,     // Connector strap pins
  input  wire [1:0] i_host_eq_straps,          // Host strap pins
  input  wire [3:0] i_full_adapt_eq_port1,     // Full adaptive result, rx 1
  input  wire [3:0] i_full_adapt_eq_port2,     // Full adaptive result, rx 2
  input  wire       i_long_chan_port1,         // Long channel seen, rx 1
  input  wire       i_long_chan_port2,         // Long channel seen, rx 2
  output reg  [3:0] o_connector_receiver_1_eq, // Applied EQ, connector rx 1
  output reg  [3:0] o_connector_receiver_2_eq, // Applied EQ, connector rx 2
  output reg  [3:0] o_host_receiver_1_eq,      // Applied EQ, host rx 1
  output reg  [3:0] o_host_receiver_2_eq,      // Applied EQ, host rx 2
  output reg        o_adapt_eq_enable,         // Adaptation enabled
  output reg  [1:0] o_adapt_eq_algorithm,      // Adaptation mode
  output reg  [8:0] o_fast_adapt_limit_mv,     // Fast decision limit, mV
  output reg        o_port1_channel_length_flag, // Long channel in use, 1
  output reg        o_port2_channel_length_flag  // Long channel in use, 2
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg        rst_s1;
  reg        rst_b;
  reg  [3:0] strap_s1;
  reg  [3:0] strap_s2;
  reg  [3:0] strap_s3;
  reg  [3:0] strap_lvl;
  reg  [2:0] settle_reg;
  reg        cap_done_reg;
  reg  [1:0] cap_conn_reg;
  reg  [1:0] cap_host_reg;
  reg        ovr_reg;
  reg  [7:0] actl_reg;
  reg  [7:0] aadj_reg;
  reg  [7:0] long_reg;
  reg  [7:0] ceq_reg;
  reg  [7:0] heq_reg;
  reg  [7:0] rd_data;
  wire [7:0] rd_addr;
  wire       wr_en;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;

  // Field views of the control registers
  wire       adapt_eq_enable   = actl_reg[`RXEQ_EN_BIT];
  wire [1:0] adapt_eq_algorithm = actl_reg[`RXEQ_MODE_HI:`RXEQ_MODE_LO];
  wire       ofs_sign = aadj_reg[`RXEQ_SIGN_BIT];
  wire [2:0] ofs_val  = aadj_reg[`RXEQ_OFS_HI:`RXEQ_OFS_LO];
  wire [2:0] thr_code = aadj_reg[`RXEQ_THR_HI:`RXEQ_THR_LO];
  wire       fast_on  = adapt_eq_enable && (adapt_eq_algorithm == `RXEQ_MODE_FAST);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  // Spreads a two-bit strap code evenly over the 16 EQ settings
  function [3:0] rxeq_strap_eq;
    input [1:0] code;
    begin
      rxeq_strap_eq = {code, code};
    end
  endfunction

  // Full adaptive result shifted by the signed offset
  function [3:0] rxeq_offset;
    input [3:0] eq;
    input       sgn;
    input [2:0] n;
    reg   [5:0] ofs;
    reg   [5:0] sum;
    begin
      ofs = 6'h00;
      sum = 6'h00;
      ofs = sgn ? ({3'h0, n} - `RXEQ_NEG_BIAS) : {3'h0, n};
      sum = {2'h0, eq} + ofs;
      if (sum[5]) begin
        rxeq_offset = 4'h0;
      end else if (sum[4]) begin
        rxeq_offset = 4'hF;
      end else begin
        rxeq_offset = sum[3:0];
      end
    end
  endfunction

  // Chooses the EQ a connector receiver runs with
  function [3:0] rxeq_pick;
    input       en;
    input [1:0] mode;
    input       long_det;
    input [3:0] long_eq;
    input [3:0] short_eq;
    input [3:0] full_eq;
    input       sgn;
    input [2:0] n;
    begin
      if (!en) begin
        rxeq_pick = short_eq;
      // Fast mode: long or short value
      end else if (mode == `RXEQ_MODE_FAST) begin
        rxeq_pick = long_det ? long_eq : short_eq;
      end else begin
        rxeq_pick = rxeq_offset(full_eq, sgn, n);
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1 <= 1'b0;
      rst_b  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_b  <= rst_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers; a level counts once stages two and three agree
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1  <= 4'h0;
      strap_s2  <= 4'h0;
      strap_s3  <= 4'h0;
      strap_lvl <= 4'h0;
    end else begin
      strap_s1 <= {i_host_eq_straps, i_connector_eq_straps};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_s2 == strap_s3) begin
        strap_lvl <= strap_s3;
      end
    end
  end

  // One capture after the pipe settles
  // Later strap movement is ignored so a bouncing pin cannot retune a lane
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg   <= 3'h0;
      cap_done_reg <= 1'b0;
      cap_conn_reg <= 2'h0;
      cap_host_reg <= 2'h0;
    end else if (!cap_done_reg) begin
      if (settle_reg == `RXEQ_SETTLE) begin
        cap_done_reg <= 1'b1;
        cap_conn_reg <= strap_lvl[1:0];
        cap_host_reg <= strap_lvl[3:2];
      end else begin
        settle_reg <= settle_reg + 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial register port
  rxeq_i2c_target #(
    .ADDR      (I2C_ADDR)
  ) u_i2c (
    .i_clk     (i_clk),
    .i_rst_b   (rst_b),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .i_rd_data (rd_data),
    .o_rd_addr (rd_addr),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_sda_out (o_sda_out),
    .o_sda_oe  (o_sda_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_reg  <= 1'b0;
      actl_reg <= `RXEQ_RST_ACTL;
      aadj_reg <= `RXEQ_RST_AADJ;
      long_reg <= `RXEQ_RST_LONG;
    end else if (wr_en) begin
      case (wr_addr)
        `RXEQ_OFF_GEN: begin
          ovr_reg <= wr_data[`RXEQ_OVR_BIT];
        end
        `RXEQ_OFF_ACTL: begin
          actl_reg <= wr_data;
        end
        // Bit 6 is reserved and kept at zero
        `RXEQ_OFF_AADJ: begin
          aadj_reg <= wr_data & `RXEQ_RSVD_MASK;
        end
        `RXEQ_OFF_LONG: begin
          long_reg <= wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // EQ select registers: straps while override low, writes while high.
  // Tracking the strap value keeps it in place when override is raised.
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ceq_reg <= `RXEQ_RST_CEQ;
      heq_reg <= `RXEQ_RST_HEQ;
    end else if (!ovr_reg) begin
      ceq_reg <= {rxeq_strap_eq(cap_conn_reg), rxeq_strap_eq(cap_conn_reg)};
      heq_reg <= {rxeq_strap_eq(cap_host_reg), rxeq_strap_eq(cap_host_reg)};
    end else if (wr_en) begin
      if (wr_addr == `RXEQ_OFF_CEQ) begin
        ceq_reg <= wr_data;
      end
      if (wr_addr == `RXEQ_OFF_HEQ) begin
        heq_reg <= wr_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data; unmapped offsets read as zero
  always @* begin
    rd_data = 8'h00;
    case (rd_addr)
      `RXEQ_OFF_GEN:  rd_data = {3'h0, ovr_reg, 4'h0};
      `RXEQ_OFF_ACTL: rd_data = actl_reg;
      `RXEQ_OFF_AADJ: rd_data = aadj_reg;
      `RXEQ_OFF_LONG: rd_data = long_reg;
      `RXEQ_OFF_CEQ:  rd_data = ceq_reg;
      `RXEQ_OFF_HEQ:  rd_data = heq_reg;
      `RXEQ_OFF_ST1:  rd_data = {o_port1_channel_length_flag, 7'h00};
      `RXEQ_OFF_ST2:  rd_data = {o_port2_channel_length_flag, 7'h00};
      default:        rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Applied settings, registered so the analog side sees glitch-free codes
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_connector_receiver_1_eq   <= 4'h0;
      o_connector_receiver_2_eq   <= 4'h0;
      o_host_receiver_1_eq        <= 4'h0;
      o_host_receiver_2_eq        <= 4'h0;
      o_adapt_eq_enable           <= 1'b0;
      o_adapt_eq_algorithm        <= 2'h0;
      o_fast_adapt_limit_mv       <= 9'h000;
      o_port1_channel_length_flag <= 1'b0;
      o_port2_channel_length_flag <= 1'b0;
    end else begin
      o_connector_receiver_2_eq <= rxeq_pick(adapt_eq_enable, adapt_eq_algorithm,
        i_long_chan_port2, long_reg[7:4], ceq_reg[7:4],
        i_full_adapt_eq_port2, ofs_sign, ofs_val);
      o_connector_receiver_1_eq <= rxeq_pick(adapt_eq_enable, adapt_eq_algorithm,
        i_long_chan_port1, long_reg[3:0], ceq_reg[3:0],
        i_full_adapt_eq_port1, ofs_sign, ofs_val);
      o_host_receiver_2_eq <= heq_reg[7:4];
      o_host_receiver_1_eq <= heq_reg[3:0];
      o_adapt_eq_enable    <= adapt_eq_enable;
      o_adapt_eq_algorithm <= adapt_eq_algorithm;
      o_fast_adapt_limit_mv <= {6'h00, thr_code} * `RXEQ_STEP_MV;
      // Flags live only in fast mode
      o_port1_channel_length_flag <= fast_on & i_long_chan_port1;
      o_port2_channel_length_flag <= fast_on & i_long_chan_port2;
    end
  end

endmodule

//--- core/rxeq_map.vh
`ifndef RXEQ_MAP_VH
`define RXEQ_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define RXEQ_OFF_GEN   8'h0A
`define RXEQ_OFF_ACTL  8'h1C
`define RXEQ_OFF_AADJ  8'h1D
`define RXEQ_OFF_LONG  8'h1E
`define RXEQ_OFF_CEQ   8'h20
`define RXEQ_OFF_HEQ   8'h21
`define RXEQ_OFF_ST1   8'h24
`define RXEQ_OFF_ST2   8'h25

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RXEQ_RST_ACTL  8'h85
`define RXEQ_RST_AADJ  8'h10
`define RXEQ_RST_LONG  8'h77
`define RXEQ_RST_CEQ   8'h00
`define RXEQ_RST_HEQ   8'h00

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RXEQ_OVR_BIT   4
`define RXEQ_EN_BIT    0
`define RXEQ_MODE_HI   2
`define RXEQ_MODE_LO   1
`define RXEQ_SIGN_BIT  7
`define RXEQ_RSVD_MASK 8'hBF
`define RXEQ_THR_HI    5
`define RXEQ_THR_LO    3
`define RXEQ_OFS_HI    2
`define RXEQ_OFS_LO    0
`define RXEQ_FLAG_BIT  7

////////////////////////////////////////////////////////////////////////////////
// Codes and counts
`define RXEQ_MODE_FAST 2'h0
`define RXEQ_NEG_BIAS  6'h08
`define RXEQ_STEP_MV   9'h028
`define RXEQ_SETTLE    3'h4

`endif

//--- core/rxeq_i2c_target.v
`timescale 1ns/100ps
module rxeq_i2c_target #(
  parameter [6:0] ADDR = 7'h2C
) (
  input  wire       i_clk,      // Device clock
  input  wire       i_rst_b,    // Synchronised reset, low active
  input  wire       i_scl,      // Serial clock pin
  input  wire       i_sda,      // Serial data pin level
  input  wire [7:0] i_rd_data,  // Data at o_rd_addr
  output wire [7:0] o_rd_addr,  // Register pointer
  output reg        o_wr_en,    // One-cycle write strobe
  output reg  [7:0] o_wr_addr,  // Write address
  output reg  [7:0] o_wr_data,  // Write data
  output reg        o_sda_out,  // Data pin drive level
  output reg        o_sda_oe    // Data pin drive enable
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_PTR  = 3'h2;
  localparam [2:0] S_WDAT = 3'h3;
  localparam [2:0] S_RDAT = 3'h4;
  localparam [2:0] S_ACK  = 3'h5;
  localparam [2:0] S_MACK = 3'h6;

  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg       scl_q;
  reg       sda_q;
  reg [2:0] st_reg;
  reg [2:0] after_reg;
  reg [3:0] cnt_reg;
  reg [7:0] sh_reg;
  reg [7:0] ptr_reg;
  reg       macked_reg;

  wire scl_ok  = (scl_s[1] == scl_s[2]);
  wire sda_ok  = (sda_s[1] == sda_s[2]);
  wire scl_new = scl_ok ? scl_s[2] : scl_q;
  wire sda_new = sda_ok ? sda_s[2] : sda_q;
  wire rise    = scl_new & ~scl_q;
  wire fall    = ~scl_new & scl_q;
  wire start   = scl_q & scl_new & sda_q & ~sda_new;
  wire stop    = scl_q & scl_new & ~sda_q & sda_new;

  assign o_rd_addr = ptr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], i_scl};
      sda_s <= {sda_s[1:0], i_sda};
      scl_q <= scl_new;
      sda_q <= sda_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine; sample on rising clock, drive on falling clock
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg     <= S_IDLE;
      after_reg  <= S_IDLE;
      cnt_reg    <= 4'h0;
      sh_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      macked_reg <= 1'b0;
      o_wr_en    <= 1'b0;
      o_wr_addr  <= 8'h00;
      o_wr_data  <= 8'h00;
      o_sda_out  <= 1'b0;
      o_sda_oe   <= 1'b0;
    end else begin
      o_wr_en   <= 1'b0;
      o_sda_out <= 1'b0;
      if (stop) begin
        st_reg   <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (start) begin
        st_reg   <= S_ADDR;
        cnt_reg  <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (rise) begin
        if (st_reg == S_ADDR || st_reg == S_PTR || st_reg == S_WDAT) begin
          sh_reg  <= {sh_reg[6:0], sda_new};
          cnt_reg <= cnt_reg + 4'h1;
        end else if (st_reg == S_MACK) begin
          macked_reg <= ~sda_new;
        end
      end else if (fall) begin
        case (st_reg)
          S_ADDR, S_PTR, S_WDAT: begin
            if (cnt_reg == 4'h8) begin
              cnt_reg  <= 4'h0;
              st_reg   <= S_ACK;
              o_sda_oe <= 1'b1;
              if (st_reg == S_ADDR) begin
                if (sh_reg[7:1] != ADDR) begin
                  st_reg   <= S_IDLE;
                  o_sda_oe <= 1'b0;
                end
                after_reg <= sh_reg[0] ? S_RDAT : S_PTR;
              end else if (st_reg == S_PTR) begin
                ptr_reg   <= sh_reg;
                after_reg <= S_WDAT;
              end else begin
                o_wr_en   <= 1'b1;
                o_wr_addr <= ptr_reg;
                o_wr_data <= sh_reg;
                ptr_reg   <= ptr_reg + 8'h01;
                after_reg <= S_WDAT;
              end
            end
          end
          S_ACK, S_MACK: begin
            if (after_reg == S_RDAT && (st_reg == S_ACK || macked_reg)) begin
              sh_reg   <= i_rd_data;
              o_sda_oe <= ~i_rd_data[7];
              cnt_reg  <= 4'h1;
              st_reg   <= S_RDAT;
            end else begin
              o_sda_oe <= 1'b0;
              st_reg   <= (st_reg == S_ACK) ? after_reg : S_IDLE;
            end
          end
          S_RDAT: begin
            if (cnt_reg == 4'h8) begin
              o_sda_oe   <= 1'b0;
              macked_reg <= 1'b0;
              ptr_reg    <= ptr_reg + 8'h01;
              st_reg     <= S_MACK;
            end else begin
              o_sda_oe <= ~sh_reg[6];
              sh_reg   <= {sh_reg[6:0], 1'b0};
              cnt_reg  <= cnt_reg + 4'h1;
            end
          end
          default: begin
            st_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

//--- sim/rxeq_regs_asserts.sv
`timescale 1ns/100ps
module rxeq_regs_asserts (
  input wire       i_clk,                       // Clock
  input wire       i_rst_b,                     // Reset, low active
  input wire       i_scl,                       // Serial clock pin
  input wire [3:0] i_full_adapt_eq_port1,       // Full result, rx 1
  input wire [3:0] i_full_adapt_eq_port2,       // Full result, rx 2
  input wire       i_long_chan_port1,           // Long seen, rx 1
  input wire       i_long_chan_port2,           // Long seen, rx 2
  input wire [3:0] o_connector_receiver_1_eq,   // Connector rx 1
  input wire [3:0] o_connector_receiver_2_eq,   // Connector rx 2
  input wire [3:0] o_host_receiver_1_eq,        // Host rx 1
  input wire       o_adapt_eq_enable,           // Adaptation on
  input wire [1:0] o_adapt_eq_algorithm,        // Mode
  input wire [8:0] o_fast_adapt_limit_mv,       // Limit
  input wire       o_port1_channel_length_flag, // Flag 1
  input wire       o_port2_channel_length_flag  // Flag 2
);
  reg  [3:0] up_cnt_reg;
  reg  [3:0] scl_hi_cnt_reg;
  wire       fast;
  wire       quiet;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  assign fast = o_adapt_eq_enable && (o_adapt_eq_algorithm == 2'h0);
  // Serial clock high for eight cycles: a write reaches the outputs within
  // seven cycles of the clock pin falling, so none is in flight then
  assign quiet = (scl_hi_cnt_reg >= 4'h8);
  // Run of serial clock high samples, saturating
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      scl_hi_cnt_reg <= 4'h0;
    else if (!i_scl)
      scl_hi_cnt_reg <= 4'h0;
    else if (scl_hi_cnt_reg != 4'hF)
      scl_hi_cnt_reg <= scl_hi_cnt_reg + 4'h1;
  end
  // Cycles since reset; strap capture settles well inside the count
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      up_cnt_reg <= 4'h0;
    else if (up_cnt_reg != 4'hF)
      up_cnt_reg <= up_cnt_reg + 4'h1;
  end
  a_limit_grid: assert property (o_fast_adapt_limit_mv <= 9'h118 &&
    (o_fast_adapt_limit_mv % 9'h028) == 9'h000) else $error("limit off grid");
  a_flag1_long: assert property (fast |->
    o_port1_channel_length_flag == $past(i_long_chan_port1)) else $error("flag 1 wrong");
  a_flag2_off: assert property (!fast |-> !o_port2_channel_length_flag)
    else $error("flag 2 set outside fast");
  a_flag2_long: assert property (fast && $past(i_long_chan_port2) |->
    o_port2_channel_length_flag) else $error("flag 2 missing");
  a_full_no_long: assert property (o_adapt_eq_enable && !fast && $past(!fast) &&
    $past(i_full_adapt_eq_port1) == $past(i_full_adapt_eq_port1, 2) && quiet
    |-> $stable(o_connector_receiver_1_eq)) else $error("full eq moved");
  a_fast_no_full: assert property (fast && $past(fast) && quiet &&
    $past(i_long_chan_port2) == $past(i_long_chan_port2, 2)
    |-> $stable(o_connector_receiver_2_eq)) else $error("fast eq moved");
  a_off_hold: assert property (!o_adapt_eq_enable && $past(!o_adapt_eq_enable)
    && quiet |-> $stable(o_connector_receiver_1_eq)) else $error("fixed eq moved");
  a_host_quiet: assert property (quiet && up_cnt_reg == 4'hF |->
    $stable(o_host_receiver_1_eq)) else $error("host eq moved idle");
endmodule

bind rxeq_regs rxeq_regs_asserts rxeq_regs_asserts_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl),
  .i_full_adapt_eq_port1(i_full_adapt_eq_port1),
  .i_full_adapt_eq_port2(i_full_adapt_eq_port2),
  .i_long_chan_port1(i_long_chan_port1), .i_long_chan_port2(i_long_chan_port2),
  .o_connector_receiver_1_eq(o_connector_receiver_1_eq),
  .o_connector_receiver_2_eq(o_connector_receiver_2_eq),
  .o_host_receiver_1_eq(o_host_receiver_1_eq), .o_adapt_eq_enable(o_adapt_eq_enable),
  .o_adapt_eq_algorithm(o_adapt_eq_algorithm), .o_fast_adapt_limit_mv(o_fast_adapt_limit_mv),
  .o_port1_channel_length_flag(o_port1_channel_length_flag),
  .o_port2_channel_length_flag(o_port2_channel_length_flag));

//--- sim/rxeq_i2c_host.sv
`timescale 1ns/100ps
// Serial bus host; data is open drain, the wire pulls up when released
module rxeq_i2c_host (
  input  wire i_clk,     // Device clock paces the bus
  input  wire i_sda,     // Resolved data wire
  output reg  o_scl,     // Serial clock, idle high
  output reg  o_sda_low  // High pulls data low
);
  localparam [7:0] DEV = 8'h58; // Device address with write bit
  reg ack;
  reg [7:0] dummy;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Half phase of 8 cycles, well above the 4-cycle minimum
  task hold;
    repeat (8) @(posedge i_clk);
  endtask
  // Data moves one cycle after the clock falls, never while it is high
  task bit_x(input b, output s);
    begin
      @(posedge i_clk);
      o_sda_low <= ~b;
      hold;
      o_scl <= 1'b1;
      hold;
      s = i_sda;
      o_scl <= 1'b0;
    end
  endtask
  task byte_x(input [7:0] d, input a, output [7:0] r);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_x(d[k], r[k]);
      bit_x(a, ack);
    end
  endtask
  task start;
    begin
      @(posedge i_clk);
      o_sda_low <= 1'b0;
      hold;
      o_scl <= 1'b1;
      hold;
      o_sda_low <= 1'b1;
      hold;
      o_scl <= 1'b0;
    end
  endtask
  task stop;
    begin
      @(posedge i_clk);
      o_sda_low <= 1'b1;
      hold;
      o_scl <= 1'b1;
      hold;
      o_sda_low <= 1'b0;
      hold;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      start;
      byte_x(DEV, 1'b1, dummy);
      byte_x(a, 1'b1, dummy);
      byte_x(d, 1'b1, dummy);
      stop;
    end
  endtask
  // Pointer write, repeated start, one byte read closed by a refusal
  task rd(input [7:0] a, output [7:0] r);
    begin
      start;
      byte_x(DEV, 1'b1, dummy);
      byte_x(a, 1'b1, dummy);
      start;
      byte_x(DEV | 8'h01, 1'b1, dummy);
      byte_x(8'hFF, 1'b1, r);
      stop;
    end
  endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps
module tb;
  localparam [31:0] TC = 32'h03050703;
  localparam [31:0] TA = 32'h12179397;
  localparam [15:0] TF1 = 16'h6E3A;
  localparam [15:0] TF2 = 16'h7F2B;
  localparam [15:0] TE1 = 16'h8F09;
  localparam [15:0] TE2 = 16'h9F0A;
  reg        i_clk;
  reg        i_rst_b;
  reg  [1:0] cs, hs;
  reg  [3:0] f1, f2;
  reg        l1, l2;
  reg  [7:0] q;
  wire       scl, hlow, oe, en, p1, p2;
  wire [3:0] c1, c2, h1, h2;
  wire [1:0] alg;
  wire [8:0] lim;
  wire       sda, so;
  integer    n_mismatch, num_checks, cyc, i;
  // Open-drain wire with pull-up
  assign sda = ~(oe | hlow);
  rxeq_regs rxeq_regs_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
    .o_sda_out(so), .o_sda_oe(oe), .i_connector_eq_straps(cs), .i_host_eq_straps(hs),
    .i_full_adapt_eq_port1(f1), .i_full_adapt_eq_port2(f2), .i_long_chan_port1(l1),
    .i_long_chan_port2(l2), .o_connector_receiver_1_eq(c1), .o_connector_receiver_2_eq(c2),
    .o_host_receiver_1_eq(h1), .o_host_receiver_2_eq(h2), .o_adapt_eq_enable(en),
    .o_adapt_eq_algorithm(alg), .o_fast_adapt_limit_mv(lim),
    .o_port1_channel_length_flag(p1), .o_port2_channel_length_flag(p2));
  rxeq_i2c_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(hlow));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [8:0] seen, input [8:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      host.rd(a, q);
      chk({1'b0, q}, {1'b0, e});
    end
  endtask
  // Outputs follow inputs by one clock; three gives margin
  task settle;
    repeat (3) @(posedge i_clk);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Hang guard, far above the run's length
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    i_rst_b = 1'b0;
    cs = 2'h1;
    hs = 2'h2;
    f1 = 4'h0;
    f2 = 4'h0;
    l1 = 1'b1;
    l2 = 1'b1;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (20) @(posedge i_clk);
    // Reset values and sampled straps
    rdchk(8'h1D, 8'h10); // reset adjust
    rdchk(8'h1E, 8'h77); // reset long
    rdchk(8'h20, 8'h55); // connector straps
    rdchk(8'h21, 8'hAA); // host straps
    chk({5'h00, h2}, 9'h00A); // host rx 2
    chk({5'h00, h1}, 9'h00A); // host rx 1
    // Refused and unmapped writes leave registers alone
    host.wr(8'h20, 8'h12);
    host.wr(8'h30, 8'h00);
    rdchk(8'h20, 8'h55); // write refused
    rdchk(8'h1E, 8'h77); // unmapped ignored
    // Software takes over the eq registers
    host.wr(8'h0A, 8'h10); // override on
    host.wr(8'h20, 8'h3C); // software value
    host.wr(8'h21, 8'h96); // software value
    rdchk(8'h20, 8'h3C); // readback
    chk({5'h00, h2}, 9'h009); // host rx 2
    chk({5'h00, h1}, 9'h006); // host rx 1
    host.wr(8'h1D, 8'hFF);
    rdchk(8'h1D, 8'hBF); // reserved bit reads 0
    for (i = 0; i < 8; i = i + 1) begin
      host.wr(8'h1D, {2'h0, i[2:0], 3'h0});
      settle;
      chk(lim, i[8:0] * 9'h028); // limit step
    end
    // Full modes: offset, sign and clamp, long detect ignored
    for (i = 0; i < 4; i = i + 1) begin
      host.wr(8'h1C, TC[31-8*i -: 8]); // full mode codes
      host.wr(8'h1D, TA[31-8*i -: 8]); // sign and offset
      f1 <= TF1[15-4*i -: 4];
      f2 <= TF2[15-4*i -: 4];
      settle;
      chk({5'h00, c1}, {5'h00, TE1[15-4*i -: 4]}); // offset applied
      chk({5'h00, c2}, {5'h00, TE2[15-4*i -: 4]}); // offset and clamp, rx 2
      chk({8'h00, p1}, 9'h000); // no flag in full
      chk({7'h00, alg}, {7'h00, TC[26-8*i -: 2]}); // mode copy
    end
    // Fast mode, long then short channel
    host.wr(8'h1C, 8'h01); // fast code
    host.wr(8'h1E, 8'hB4); // long values
    f1 <= 4'h0;
    settle;
    chk({5'h00, c2}, 9'h00B); // long rx 2
    chk({5'h00, c1}, 9'h004); // long rx 1
    chk({7'h00, p2, p1}, 9'h003); // long flags
    rdchk(8'h24, 8'h80); // status long
    rdchk(8'h25, 8'h80); // status long, port 2
    l1 <= 1'b0;
    l2 <= 1'b0;
    settle;
    chk({5'h00, c2}, 9'h003); // short rx 2
    chk({5'h00, c1}, 9'h00C); // short rx 1
    chk({7'h00, p2, p1}, 9'h000); // short flags
    // Adaptation off: fixed fields, flag 1 forced low
    host.wr(8'h1C, 8'h00); // disable
    l1 <= 1'b1;
    settle;
    chk({5'h00, c1}, 9'h00C); // fixed rx 1
    chk({5'h00, c2}, 9'h003); // fixed rx 2
    chk({7'h00, en, p1}, 9'h000); // flag off
    // Back to straps; late strap moves are not sampled
    host.wr(8'h0A, 8'h00); // override off
    cs <= 2'h3;
    hs <= 2'h0;
    settle;
    rdchk(8'h21, 8'hAA); // straps held
    chk({5'h00, c1}, 9'h005); // strap eq applied
    chk({5'h00, h1}, 9'h00A); // host strap held
    chk({8'h00, so}, 9'h000); // open-drain drive level
    give_verdict;
  end
endmodule
